//--- standby_reset_pkg.sv
// Package with constants, states and carrier structs for the standby and reset sequencer.
// Contract
// R1: Standby attribute holds none or standby.
// R2: NACK bus START until wake latency elapses.
// R3: Auto standby after configured bus idle time.
// R4: Idle timeout 50 to 1600 ms, 50 ms steps.
// R5: Host polls between wake latency and timeout; the bench polls again 14000 cycles after the first, inside the wake latency.
// R6: Host keeps standby enabled on shared bus; the bench writes none once.
// R7: Security detector forces latched reset state.
// R8: Host drives reset pin from own output.
// R9: Reset low holds reset; under 5 us ignored.
// R10: Floating reset pin keeps device in reset.
// R11: Qualified low pulse gives warm reset.
// R12: Commands accepted 4.5 ms typ, 20 ms max.
// R13: Host holds reset low before supply.
// R14: Attribute write sets low power setting.
// R15: Reset stays low while supply removed.
// R16: Idle timer restarts on activity, counts awake.
// R17: Attribute none never enters standby.
package standby_reset_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ              = 250;
    localparam int WAKE_US              = 60;
    localparam int WAKE_CYC             = WAKE_US * CLK_MHZ;
    localparam int RESET_MIN_US         = 5;
    localparam int RESET_MIN_CYC        = RESET_MIN_US * CLK_MHZ;
    localparam int ACCEPT_DELAY_US      = 4500;
    localparam int ACCEPT_DELAY_CYC     = ACCEPT_DELAY_US * CLK_MHZ;
    localparam int STEP_MS              = 50;
    localparam int STEP_CYC             = STEP_MS * 1000 * CLK_MHZ;
    localparam int STEP_MIN             = 1;
    localparam int STEP_MAX             = 32;
    localparam int CNT_W                = 32;
    localparam int STEP_W               = 6;

    // ------------------------------------------------------------------
    // Attribute values and states
    // ------------------------------------------------------------------
    localparam logic ATTR_NONE          = 1'h0;
    localparam logic ATTR_STANDBY       = 1'h1;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_BOOT,
        ST_AWAKE,
        ST_STANDBY,
        ST_WAKING
    } pwr_state_t;

    typedef struct packed {
        logic             valid;
        logic             standby;
        logic [STEP_W-1:0] steps;
    } attr_write_t;

    typedef struct packed {
        pwr_state_t        state;
        logic [1:0]        rstSync;
        logic [1:0]        detSync;
        logic [CNT_W-1:0]  lowCnt;
        logic [CNT_W-1:0]  timer;
        logic [STEP_W-1:0] stepCnt;
        logic              lowPower;
        logic [STEP_W-1:0] idleSteps;
        logic              alarm;
    } seq_state_t;

endpackage

//--- standby_and_reset_sequencer.sv
// Standby entry, wake-up, reset pin filter and command accept delay.
`timescale 1ns/10ps
module standby_and_reset_sequencer #(
    parameter int ACCEPT_CYC = standby_reset_pkg::ACCEPT_DELAY_CYC,
    parameter int STEP_CYCP  = standby_reset_pkg::STEP_CYC
) (
    input  wire logic                           clk,          // 250 MHz clock
    input  wire logic                           rst,          // Sync reset, active high
    input  wire logic                           resetPinN,    // Reset pin, pad pulled low
    input  wire logic                           detectorHit,  // Security detector alarm
    input  wire standby_reset_pkg::attr_write_t attrWrite,    // Attribute write strobe
    input  wire logic                           busStart,     // START seen, addressed
    input  wire logic                           busActive,    // Bus activity for device
    output logic                                startNack,    // Refuse current START
    output logic                                cmdReady,     // Commands accepted
    output logic                                inReset,      // Device held in reset
    output logic                                inStandby     // Standby or waking
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    standby_reset_pkg::seq_state_t s_r;
    standby_reset_pkg::seq_state_t s_nxt;
    logic pinLow;
    logic pinReset;
    // Last legal count of the boot phase, sized to the state counter.
    localparam logic [standby_reset_pkg::CNT_W-1:0] CNT_W_ACCEPT_LAST =
        standby_reset_pkg::CNT_W'(ACCEPT_CYC - 1);

    // The pad pull-down makes a floating pin read low, so it stays in reset.
    assign pinLow   = ~s_r.rstSync[1];                                       // [R10]
    // Short lows are ignored; only a qualified width asserts reset.
    assign pinReset = pinLow && (s_r.lowCnt >= standby_reset_pkg::CNT_W'(
                      standby_reset_pkg::RESET_MIN_CYC - 1));                 // [R9]

    always_comb begin
        s_nxt         = s_r;
        s_nxt.rstSync = {s_r.rstSync[0], resetPinN};
        s_nxt.detSync = {s_r.detSync[0], detectorHit};
        if (pinLow && !pinReset) begin
            s_nxt.lowCnt = s_r.lowCnt + 1'b1;
        end else if (!pinLow) begin
            s_nxt.lowCnt = '0;
        end
        if (attrWrite.valid) begin                                            // [R14]
            s_nxt.lowPower = attrWrite.standby;                               // [R1]
            if (attrWrite.steps >= standby_reset_pkg::STEP_W'(standby_reset_pkg::STEP_MIN)
                && attrWrite.steps <= standby_reset_pkg::STEP_W'(standby_reset_pkg::STEP_MAX))
            begin
                s_nxt.idleSteps = attrWrite.steps;                            // [R4]
            end
        end
        if (s_r.detSync[1]) begin
            s_nxt.alarm = 1'b1;                                               // [R7]
        end
        case (s_r.state)
            standby_reset_pkg::ST_RESET: begin
                s_nxt.timer = '0;
                if (!pinReset && !pinLow && !s_r.alarm && !s_r.detSync[1]) begin
                    s_nxt.state = standby_reset_pkg::ST_BOOT;                 // [R11]
                end
            end
            standby_reset_pkg::ST_BOOT: begin
                s_nxt.timer = s_r.timer + 1'b1;
                if (s_r.timer >= standby_reset_pkg::CNT_W'(ACCEPT_CYC - 1)) begin
                    s_nxt.state   = standby_reset_pkg::ST_AWAKE;              // [R12]
                    s_nxt.timer   = '0;
                    s_nxt.stepCnt = '0;
                end
            end
            standby_reset_pkg::ST_AWAKE: begin
                if (busActive || busStart || s_r.lowPower == standby_reset_pkg::ATTR_NONE)
                begin
                    s_nxt.timer   = '0;                                       // [R16] [R17]
                    s_nxt.stepCnt = '0;
                end else if (s_r.timer >= standby_reset_pkg::CNT_W'(STEP_CYCP - 1)) begin
                    s_nxt.timer   = '0;
                    s_nxt.stepCnt = s_r.stepCnt + 1'b1;
                    if (s_r.stepCnt + 1'b1 >= s_r.idleSteps) begin
                        s_nxt.state   = standby_reset_pkg::ST_STANDBY;        // [R3]
                        s_nxt.stepCnt = '0;
                    end
                end else begin
                    s_nxt.timer = s_r.timer + 1'b1;
                end
            end
            standby_reset_pkg::ST_STANDBY: begin
                s_nxt.timer = '0;
                if (busStart) begin
                    s_nxt.state = standby_reset_pkg::ST_WAKING;
                end
            end
            standby_reset_pkg::ST_WAKING: begin
                s_nxt.timer = s_r.timer + 1'b1;
                if (s_r.timer >= standby_reset_pkg::CNT_W'(standby_reset_pkg::WAKE_CYC - 1))
                begin
                    s_nxt.state = standby_reset_pkg::ST_AWAKE;                // [R2]
                    s_nxt.timer = '0;
                end
            end
            default: begin
                s_nxt.state = standby_reset_pkg::ST_RESET;
            end
        endcase
        // Reset entry overrides everything; alarm clears only on a pin reset.
        if (pinReset) begin
            s_nxt.state = standby_reset_pkg::ST_RESET;                        // [R9]
            s_nxt.alarm = s_r.detSync[1];
        end else if (s_r.detSync[1] || s_r.alarm) begin
            s_nxt.state = standby_reset_pkg::ST_RESET;                        // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r           <= '0;
            s_r.state     <= standby_reset_pkg::ST_RESET;
            s_r.lowPower  <= standby_reset_pkg::ATTR_NONE;
            s_r.idleSteps <= standby_reset_pkg::STEP_W'(standby_reset_pkg::STEP_MIN);
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        inReset   = (s_r.state == standby_reset_pkg::ST_RESET);
        cmdReady  = (s_r.state == standby_reset_pkg::ST_AWAKE);
        inStandby = (s_r.state == standby_reset_pkg::ST_STANDBY)
                    || (s_r.state == standby_reset_pkg::ST_WAKING);
        startNack = busStart && !cmdReady;                                    // [R2]
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Long waits are bounded through the state counters rather than long repetitions,
    // which keeps every property cheap to evaluate at full-scale timing.
    a_nack_standby: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        busStart && inStandby |-> startNack
    ) else $error("START not refused");

    a_wake_time: assert property ( // [R2]
        @(posedge clk) disable iff (rst || pinReset || s_r.alarm)
        $rose(s_r.state == standby_reset_pkg::ST_WAKING) |-> !cmdReady [*8]
    ) else $error("woke too early");

    a_wake_bound: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        s_r.state == standby_reset_pkg::ST_WAKING
        |-> s_r.timer <= standby_reset_pkg::CNT_W'(standby_reset_pkg::WAKE_CYC - 1)
    ) else $error("wake counter overrun");

    a_standby_hold: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        s_r.state == standby_reset_pkg::ST_STANDBY && !busStart && !pinReset
        && !s_r.detSync[1] && !s_r.alarm |=> inStandby && !cmdReady
    ) else $error("left standby without START");

    a_attr_store: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        attrWrite.valid |=> s_r.lowPower == $past(attrWrite.standby)
    ) else $error("attribute lost");

    a_none_awake: assert property ( // [R17]
        @(posedge clk) disable iff (rst)
        cmdReady && s_r.lowPower == standby_reset_pkg::ATTR_NONE && !pinReset
        && !s_r.detSync[1] && !s_r.alarm |=> cmdReady
    ) else $error("left awake");

    a_none_timer: assert property ( // [R17]
        @(posedge clk) disable iff (rst)
        cmdReady && s_r.lowPower == standby_reset_pkg::ATTR_NONE |=> s_r.timer == '0
    ) else $error("idle timer ran with standby off");

    a_step_range: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        s_r.idleSteps >= standby_reset_pkg::STEP_W'(standby_reset_pkg::STEP_MIN)
        && s_r.idleSteps <= standby_reset_pkg::STEP_W'(standby_reset_pkg::STEP_MAX)
    ) else $error("bad steps");

    a_standby_entry: assert property ( // [R3]
        @(posedge clk) disable iff (rst)
        $rose(s_r.state == standby_reset_pkg::ST_STANDBY)
        |-> $past(s_r.lowPower) == standby_reset_pkg::ATTR_STANDBY
    ) else $error("standby without attribute");

    a_alarm_reset: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        s_r.detSync[1] |=> inReset
    ) else $error("alarm not reset");

    a_pin_reset: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        pinReset |=> inReset
    ) else $error("qualified low ignored");

    a_short_ignored: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        cmdReady && pinLow && !s_r.alarm && !s_r.detSync[1]
        && s_r.lowCnt < standby_reset_pkg::CNT_W'(standby_reset_pkg::RESET_MIN_CYC - 1)
        |=> !inReset
    ) else $error("short pulse reset");

    a_floating_pin: assert property ( // [R10]
        @(posedge clk) disable iff (rst)
        inReset && pinLow |=> inReset
    ) else $error("left reset with pin low");

    a_warm_release: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        inReset && !pinLow && !s_r.alarm && !s_r.detSync[1] |=> !inReset
    ) else $error("no warm reset release");

    a_boot_ready: assert property ( // [R12]
        @(posedge clk) disable iff (rst)
        $fell(inReset) |-> !cmdReady [*8]
    ) else $error("ready too soon");

    a_accept_bound: assert property ( // [R12]
        @(posedge clk) disable iff (rst)
        s_r.state == standby_reset_pkg::ST_BOOT |-> s_r.timer <= CNT_W_ACCEPT_LAST
    ) else $error("accept delay overrun");

    a_idle_restart: assert property ( // [R16]
        @(posedge clk) disable iff (rst)
        cmdReady && busActive |=> s_r.timer == '0
    ) else $error("no restart");

    a_idle_frozen: assert property ( // [R16]
        @(posedge clk) disable iff (rst)
        inReset || s_r.state == standby_reset_pkg::ST_STANDBY |=> s_r.timer == '0
    ) else $error("idle timer ran while not awake");

    c_standby: cover property (@(posedge clk) $rose(inStandby));
    c_wake: cover property (@(posedge clk) $fell(inStandby) && cmdReady);
    c_warm: cover property (@(posedge clk) $rose(inReset));
    c_ready: cover property (@(posedge clk) $rose(cmdReady));
    c_alarm: cover property (@(posedge clk) $rose(s_r.alarm));

endmodule

//--- host_model.sv
// Host processor model driving the reset pin, bus events and attribute writes.
`timescale 1ns/10ps
module host_model (
    input  wire logic                           clk,       // System clock
    input  wire logic                           startNack, // Refusal of a START
    output logic                                resetPinN, // Reset pin drive
    output logic                                busStart,  // Addressed START
    output logic                                busActive, // Bus activity
    output standby_reset_pkg::attr_write_t      attrWrite  // Attribute write
);
    initial begin
        resetPinN = 1'h0;
        busStart = 1'h0;
        busActive = 1'h0;
        attrWrite = '0;
    end
    // The pin comes from a host output, so an alarm can be cleared by a pin reset.
    task automatic pinLow(input int n);
        @(negedge clk) resetPinN = 1'h0;
        repeat (n) @(negedge clk);
        resetPinN = 1'h1;
    endtask
    // One poll drives an addressed START for one cycle and samples the refusal; the bench spaces polls inside the wake latency.
    task automatic start(output logic nack);
        @(negedge clk) busStart = 1'h1;
        #1 nack = startNack;
        @(negedge clk) busStart = 1'h0;
    endtask
    task automatic activity();
        @(negedge clk) busActive = 1'h1;
        @(negedge clk) busActive = 1'h0;
    endtask
    // Writes standby or none as given by sb; the bench also writes none once.
    task automatic writeAttr(input logic sb, input logic [5:0] st);
        @(negedge clk) attrWrite = '{1'h1, sb, st};
        @(negedge clk) attrWrite = '0;
    endtask
endmodule

//--- standby_and_reset_sequencer_tb.sv
// Self-checking bench for the standby and reset sequencer.
`timescale 1ns/10ps
module standby_and_reset_sequencer_tb;
    // Short counts keep the run brief; the wake-time expectation uses the full WAKE_CYC instead.
    localparam int ACC = 200;
    localparam int STP = 100;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic detectorHit = 1'h0;
    logic resetPinN, busStart, busActive, startNack, cmdReady, inReset, inStandby, nack;
    logic sawReset = 1'h0;
    standby_reset_pkg::attr_write_t attrWrite;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    always #2 clk = ~clk;
    standby_and_reset_sequencer #(.ACCEPT_CYC(ACC), .STEP_CYCP(STP)) dut (.clk(clk),
        .rst(rst), .resetPinN(resetPinN), .detectorHit(detectorHit), .attrWrite(attrWrite),
        .busStart(busStart), .busActive(busActive), .startNack(startNack),
        .cmdReady(cmdReady), .inReset(inReset), .inStandby(inStandby));
    host_model host (.clk(clk), .startNack(startNack), .resetPinN(resetPinN),
        .busStart(busStart), .busActive(busActive), .attrWrite(attrWrite));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (inReset === 1'h1) sawReset <= 1'h1;
        if (cyc == 90000) begin
            fails++;
            conclude();
        end
    end
    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic waitReady();
        n = 0;
        while (cmdReady !== 1'h1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic tPinReset(input int w, input logic expReset);
        @(negedge clk) sawReset = 1'h0;
        host.pinLow(w);
        repeat (4) @(negedge clk);
        check("pin reset seen", {31'h0, expReset}, {31'h0, sawReset});
        waitReady();
        check("accept delay", 32'h1, expReset ? (n >= ACC - 6 && n <= ACC + 6) : (n == 0));
    endtask
    task automatic tStandby(input logic [5:0] st);
        host.writeAttr(1'h1, st);
        n = 0;
        while (inStandby !== 1'h1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check("idle entry", 32'h1, n >= st * STP - 2 && n <= st * STP + 4);
        host.start(nack);
        check("nack asleep", 32'h1, {31'h0, nack});
        repeat (14000) @(negedge clk);
        host.start(nack);
        check("nack waking", 32'h1, {31'h0, nack});
        waitReady();
        check("wake time", 32'h1, n >= standby_reset_pkg::WAKE_CYC - 14006
              && n <= standby_reset_pkg::WAKE_CYC - 13998);
        host.start(nack);
        check("ack awake", 32'h0, {31'h0, nack});
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'h0;
        repeat (20) @(negedge clk);
        check("floating pin", 32'h1, {31'h0, inReset});
        tPinReset(1300, 1'h1);
        tPinReset(1200, 1'h0);
        tPinReset(1300, 1'h1);
        host.writeAttr(1'h0, 6'h02);
        repeat (4000) @(negedge clk);
        check("none stays awake", 32'h0, {31'h0, inStandby});
        tStandby(6'h01);
        host.writeAttr(1'h1, 6'h02);
        repeat (8) begin
            repeat (150) @(negedge clk);
            host.activity();
        end
        check("activity restarts", 32'h0, {31'h0, inStandby});
        tStandby(6'h20);
        @(negedge clk) detectorHit = 1'h1;
        @(negedge clk) detectorHit = 1'h0;
        repeat (2000) @(negedge clk);
        check("alarm latched", 32'h1, {31'h0, inReset});
        tPinReset(1300, 1'h1);
        check("ready after alarm", 32'h1, {31'h0, cmdReady});
        conclude();
    end
endmodule
